// [core/spu_pkg.sv]
// Shared constants and types of the serial port block
package spu_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0]  IDX_CONTROL     = 8'h98;
   localparam logic [7:0]  IDX_DATA        = 8'h99;
   localparam logic [7:0]  IDX_POWER       = 8'h87;
   localparam logic [7:0]  IDX_TMODE       = 8'h89;
   localparam logic [7:0]  IDX_RELOAD      = 8'h8d;
   localparam logic [7:0]  IDX_BRG         = 8'ha0;
   // Single-bit window: byte address = BIT_BASE + 4 * bit address
   localparam logic [11:0] BIT_BASE        = 12'h800;
   localparam logic [7:0]  BIT_CTRL_FIRST  = 8'h98;
   localparam logic [7:0]  BIT_CTRL_LAST   = 8'h9f;
   localparam logic [7:0]  BIT_RATE_DOUBLE = 8'h97;
   // Control, power and generator register fields
   localparam int          CTL_MODE_HI     = 7;
   localparam int          CTL_MODE_LO     = 6;
   localparam int          CTL_MP_EN       = 5;
   localparam int          CTL_RX_EN       = 4;
   localparam int          CTL_TX_NINTH    = 3;
   localparam int          CTL_RX_NINTH    = 2;
   localparam int          CTL_TX_FLAG     = 1;
   localparam int          CTL_RX_FLAG     = 0;
   localparam int          PWR_RATE_DOUBLE = 7;
   localparam int          BRG_SRC_SEL     = 16;
   // Reset values
   localparam logic [7:0]  CONTROL_RST     = 8'h00;
   localparam logic [7:0]  POWER_RST       = 8'h00;
   localparam logic [7:0]  TMODE_RST       = 8'h00;
   localparam logic [7:0]  RELOAD_RST      = 8'h00;
   localparam logic [16:0] BRG_RST         = 17'h00000;
   // Timing counts in clocks or oversample ticks
   localparam logic [3:0]  MCYCLE_CLKS     = 4'hc;
   localparam logic [3:0]  SCLK_HIGH_PHASE = 4'h6;
   localparam logic [3:0]  SYNC_SAMPLE_PH  = 4'h9;
   localparam logic [2:0]  FIX_TICK_CLKS   = 3'h4;
   localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0]  VOTE_FIRST      = 4'h7;
   localparam logic [3:0]  VOTE_LAST       = 4'h9;
   localparam logic [3:0]  DATA_BITS       = 4'h8;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_8BIT  = 2'b01,
      MODE_9FIX  = 2'b10,
      MODE_9VAR  = 2'b11
   } spu_mode_e;
endpackage

// [core/spu_tick_if.sv]
// Timing strobes from the rate generator to the serial engines
interface spu_tick_if;
   logic       sample16;
   logic       mcycle;
   logic [3:0] mphase;
   modport gen (output sample16, output mcycle, output mphase);
   modport use_ (input sample16, input mcycle, input mphase);
endinterface

// [core/spu_rate_gen.sv]
// Machine cycle and bit-rate tick generator
module spu_rate_gen (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [1:0]  mode,
   input  wire logic        rate_double,
   input  wire logic [7:0]  reload_byte,
   input  wire logic [16:0] brg_cfg,
   spu_tick_if.gen          tk
);
   logic [3:0]  phase_q;
   logic [7:0]  t1_q;
   logic [15:0] brg_q;
   logic        half_q;
   logic [2:0]  fix_q;
   logic        t1_ovf, brg_ovf, ovf, fix_tick;
   logic [2:0]  fix_lim;

   // Machine cycle: twelve oscillator clocks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) phase_q <= 4'h0;
      else if (phase_q == spu_pkg::MCYCLE_CLKS - 4'h1) phase_q <= 4'h0;
      else phase_q <= phase_q + 4'h1;
   end
   assign tk.mphase = phase_q;
   assign tk.mcycle = (phase_q == spu_pkg::MCYCLE_CLKS - 4'h1);

   // Timer 1 in auto-reload mode, counting machine cycles
   assign t1_ovf = tk.mcycle && (t1_q == 8'hff);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) t1_q <= 8'h00;
      else if (t1_ovf) t1_q <= reload_byte; // RULE19
      else if (tk.mcycle) t1_q <= t1_q + 8'h01;
   end

   // Internal generator, counting every clock for finer rates
   assign brg_ovf = (brg_q == 16'hffff);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) brg_q <= 16'h0000;
      else if (brg_ovf) brg_q <= brg_cfg[15:0];
      else brg_q <= brg_q + 16'h0001;
   end

   // Overflow to 16x tick: halve unless the rate is doubled
   assign ovf = brg_cfg[spu_pkg::BRG_SRC_SEL] ? brg_ovf : t1_ovf;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) half_q <= 1'b0;
      else if (ovf) half_q <= ~half_q;
   end

   // Fixed-rate 9-bit mode: oscillator over 4 or 2 for 16x
   assign fix_lim  = rate_double ? (spu_pkg::FIX_TICK_CLKS >> 1) - 3'h1
                                 : spu_pkg::FIX_TICK_CLKS - 3'h1; // RULE15
   assign fix_tick = (fix_q >= fix_lim);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) fix_q <= 3'h0;
      else if (fix_tick) fix_q <= 3'h0;
      else fix_q <= fix_q + 3'h1;
   end

   assign tk.sample16 = (mode == spu_pkg::MODE_9FIX) ? fix_tick
                                                     : ovf && (rate_double || half_q); // RULE17
endmodule

// [core/spu_rx_sampler.sv]
// Receive line oversampler with start detection and 2-of-3 vote
module spu_rx_sampler (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic sample16,
   input  wire logic rxd,
   input  wire logic hunt,
   output logic      start_det,
   output logic      bit_stb,
   output logic      bit_val
);
   logic       prev_q;
   logic [3:0] cnt_q;
   logic [1:0] vote_q;

   // Falling edge resets the bit-time counter to align with the frame
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q    <= 1'b1;
         cnt_q     <= 4'h0;
         start_det <= 1'b0;
      end else begin
         start_det <= 1'b0;
         if (sample16) begin
            prev_q <= rxd;
            if (hunt && prev_q && !rxd) begin
               cnt_q     <= 4'h0;
               start_det <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end

   // Three samples mid-bit; majority rejects short glitches
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vote_q  <= 2'b00;
         bit_stb <= 1'b0;
         bit_val <= 1'b1;
      end else begin
         bit_stb <= 1'b0;
         if (sample16 && cnt_q == spu_pkg::VOTE_FIRST) vote_q[0] <= rxd;
         if (sample16 && cnt_q == spu_pkg::VOTE_FIRST + 4'h1) vote_q[1] <= rxd;
         if (sample16 && cnt_q == spu_pkg::VOTE_LAST) begin
            bit_stb <= 1'b1;
            bit_val <= (vote_q[0] & vote_q[1]) | (vote_q[0] & rxd) | (vote_q[1] & rxd);
         end
      end
   end
endmodule

// [core/spu_top.sv]
// Serial port: four modes, multiprocessor filter, APB registers
//
// Overview of operation
// RULE1 - Two mode bits pick shift mode, 8-bit, fixed 9-bit or variable 9-bit.
// RULE2 - Control byte holds mode, mp enable, rx enable, ninth bits, flags; bit-addressable.
// RULE3 - 9-bit modes with mp enable: frame with ninth bit 0 raises no flag.
// RULE4 - 8-bit mode with mp enable: flag only after a valid stop bit.
// RULE5 - Multiprocessor enable has no effect in shift mode.
// RULE6 - Reception only while rx enable is 1; only software changes it.
// RULE7 - 9-bit modes send the transmit ninth bit as ninth data bit.
// RULE8 - Received ninth field takes ninth bit, or stop bit in 8-bit mode.
// RULE9 - Transmit flag set after 8th bit or at stop start; software clears.
// RULE10 - Receive flag set after 8th bit or mid stop bit; software clears.
// RULE11 - Any write to the data buffer starts a transmission.
// RULE12 - Shift mode reception starts when receive flag 0 and rx enable 1.
// RULE13 - Async modes start reception on a start bit when rx enable 1.
// RULE14 - Sender marks address bytes ninth bit 1, data bytes 0.
// RULE15 - Fixed 9-bit mode runs at oscillator over 64, or 32 when doubled.
// RULE16 - Rate-double bit is power register bit 7, resets 0, bit address 97.
// RULE17 - Variable modes on timer 1: overflow rate times 2^double over 32.
// RULE18 - Variable modes may instead use the internal rate generator.
// RULE19 - Auto-reload timer gives rate from oscillator, 12 and reload byte.
// RULE20 - Software keeps the timer 1 interrupt off when it clocks the port.
// RULE21 - Very low rates by 16-bit timer with software reload; here timer 1 is always 8-bit auto-reload and the timer mode byte has no effect.
// RULE22 - Data buffer writes go to transmit, reads come from receive register.
// RULE23 - Async frame: start 0, 8 data LSB first, optional ninth, stop 1.
// RULE24 - Shift mode: data on receive pin, shift clock on transmit pin.
// RULE25 - One received byte buffered; unread byte causes the next to be lost.
// RULE26 - Interrupt request is transmit flag OR receive flag.
module spu_top (
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        RXD_I,
   output logic             RXD_O,
   output logic             RXD_OE_N,
   output logic             TXD,
   output logic             SERIAL_IRQ
);
   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_WAIT  = 4'b0010,
      TX_SHIFT = 4'b0100,
      TX_STOP  = 4'b1000
   } spu_tx_e;
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_ASYNC = 3'b010,
      RX_SYNC  = 3'b100
   } spu_rx_e;

   // Software-visible state
   logic [7:0]  ctrl_q, ctrl_d;
   logic [7:0]  pwr_q;
   logic [7:0]  tmode_q;
   logic [7:0]  reload_q;
   logic [16:0] brg_q;
   logic [7:0]  tx_hold_q;
   logic [7:0]  rx_buf_q;

   // Engine state
   spu_tx_e     tx_q;
   spu_rx_e     rx_q;
   logic [9:0]  tx_sr_q;
   logic [3:0]  tx_cnt_q;
   logic [3:0]  tx_div_q;
   logic [7:0]  rx_sr_q;
   logic        rx_ninth_q;
   logic [3:0]  rx_cnt_q;

   // Bus decode
   logic        acc, wr_en, rd_phase;
   logic        in_word, in_bit;
   logic [7:0]  idx;
   logic        hit;
   logic [31:0] rd_mux;
   logic        bit_ctrl, bit_rd;
   logic [2:0]  bit_sel;

   // Mode and engine strobes
   spu_pkg::spu_mode_e mode;
   logic        nine, shift_mode;
   logic        tx_start, tx_bound;
   logic        ti_set, ri_set;
   logic [7:0]  rx_load_data;
   logic        rx_load_ninth;
   logic        sync_busy;
   logic        start_det, bit_stb, bit_val, hunt;
   logic        mp_pass;

   spu_tick_if tk ();

   spu_rate_gen u_rate (
      .clk         (CLOCK),
      .arst_n      (ARST_N),
      .mode        (ctrl_q[spu_pkg::CTL_MODE_HI:spu_pkg::CTL_MODE_LO]),
      .rate_double (pwr_q[spu_pkg::PWR_RATE_DOUBLE]),
      .reload_byte (reload_q),
      .brg_cfg     (brg_q),
      .tk          (tk.gen)
   );

   spu_rx_sampler u_samp (
      .clk       (CLOCK),
      .arst_n    (ARST_N),
      .sample16  (tk.sample16),
      .rxd       (RXD_I),
      .hunt      (hunt),
      .start_det (start_det),
      .bit_stb   (bit_stb),
      .bit_val   (bit_val)
   );

   // Mode decode
   assign mode       = spu_pkg::spu_mode_e'(ctrl_q[spu_pkg::CTL_MODE_HI:spu_pkg::CTL_MODE_LO]); // RULE1
   assign nine       = ctrl_q[spu_pkg::CTL_MODE_HI];   // RULE1
   assign shift_mode = (mode == spu_pkg::MODE_SHIFT);  // RULE1

   // APB: one wait state so read data can come from a flip-flop
   assign acc      = PSEL && PENABLE;
   assign rd_phase = acc && !PREADY;
   assign wr_en    = acc && PREADY && PWRITE;
   assign in_word  = (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00);
   assign in_bit   = (PADDR[11:10] == spu_pkg::BIT_BASE[11:10]) && (PADDR[1:0] == 2'b00);
   assign idx      = PADDR[9:2];
   assign bit_ctrl = in_bit && idx >= spu_pkg::BIT_CTRL_FIRST && idx <= spu_pkg::BIT_CTRL_LAST;
   assign bit_sel  = idx[2:0] - spu_pkg::BIT_CTRL_FIRST[2:0];

   // Read multiplexer; the data word returns the receive side only
   always_comb begin
      rd_mux = 32'h0000_0000;
      hit    = 1'b1;
      bit_rd = 1'b0;
      if (bit_ctrl) begin
         bit_rd = ctrl_q[bit_sel]; // RULE2
         rd_mux = {31'h0000_0000, bit_rd};
      end else if (in_bit && idx == spu_pkg::BIT_RATE_DOUBLE) begin
         rd_mux = {31'h0000_0000, pwr_q[spu_pkg::PWR_RATE_DOUBLE]}; // RULE16
      end else if (in_word) begin
         unique case (idx)
            spu_pkg::IDX_CONTROL: rd_mux = {24'h000000, ctrl_q};
            spu_pkg::IDX_DATA:    rd_mux = {24'h000000, rx_buf_q}; // RULE22
            spu_pkg::IDX_POWER:   rd_mux = {24'h000000, pwr_q};
            spu_pkg::IDX_TMODE:   rd_mux = {24'h000000, tmode_q};
            spu_pkg::IDX_RELOAD:  rd_mux = {24'h000000, reload_q};
            spu_pkg::IDX_BRG:     rd_mux = {15'h0000, brg_q};
            default:              hit    = 1'b0;
         endcase
      end else begin
         hit = 1'b0;
      end
   end

   // Bus answer registers
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= rd_phase;
         PSLVERR <= rd_phase && !hit;
         if (rd_phase) PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      end
   end

   // Control byte: software writes first, hardware events last so a set wins
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_en && in_word && idx == spu_pkg::IDX_CONTROL) ctrl_d = PWDATA[7:0]; // RULE2
      if (wr_en && bit_ctrl) ctrl_d[bit_sel] = PWDATA[0]; // RULE2
      if (ri_set) ctrl_d[spu_pkg::CTL_RX_NINTH] = rx_load_ninth; // RULE8
      if (ti_set) ctrl_d[spu_pkg::CTL_TX_FLAG] = 1'b1; // RULE9
      if (ri_set) ctrl_d[spu_pkg::CTL_RX_FLAG] = 1'b1; // RULE10
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) ctrl_q <= spu_pkg::CONTROL_RST;
      else ctrl_q <= ctrl_d;
   end

   // Power byte; only the rate-double bit acts here
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         pwr_q <= spu_pkg::POWER_RST; // RULE16
      end else if (wr_en && in_word && idx == spu_pkg::IDX_POWER) begin
         pwr_q <= PWDATA[7:0];
      end else if (wr_en && in_bit && idx == spu_pkg::BIT_RATE_DOUBLE) begin
         pwr_q[spu_pkg::PWR_RATE_DOUBLE] <= PWDATA[0]; // RULE16
      end
   end

   // Timer mode, reload byte and internal generator setup
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tmode_q  <= spu_pkg::TMODE_RST;
         reload_q <= spu_pkg::RELOAD_RST;
         brg_q    <= spu_pkg::BRG_RST;
      end else if (wr_en && in_word) begin
         if (idx == spu_pkg::IDX_TMODE) tmode_q <= PWDATA[7:0];
         if (idx == spu_pkg::IDX_RELOAD) reload_q <= PWDATA[7:0]; // RULE19
         if (idx == spu_pkg::IDX_BRG) brg_q <= PWDATA[16:0]; // RULE18
      end
   end

   // Transmit holding byte; a write always restarts the sender
   assign tx_start = wr_en && in_word && idx == spu_pkg::IDX_DATA; // RULE11
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) tx_hold_q <= 8'h00;
      else if (tx_start) tx_hold_q <= PWDATA[7:0]; // RULE22
   end

   // Free divide-by-16 so async bit edges follow the rate, not the write
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) tx_div_q <= 4'h0;
      else if (tk.sample16) tx_div_q <= tx_div_q + 4'h1;
   end
   assign tx_bound = shift_mode ? tk.mcycle
                                : tk.sample16 && tx_div_q == spu_pkg::OVERSAMPLE_LAST;

   // Transmit engine
   assign ti_set = tx_bound && tx_cnt_q == 4'h0 &&
                   ((tx_q == TX_SHIFT && !shift_mode) ||
                    (tx_q == TX_SHIFT && shift_mode)); // RULE9
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tx_q     <= TX_IDLE;
         tx_sr_q  <= 10'h3ff;
         tx_cnt_q <= 4'h0;
      end else if (tx_start) begin
         tx_q <= TX_WAIT; // RULE11
      end else if (tx_bound) begin
         unique case (tx_q)
            TX_IDLE: tx_q <= TX_IDLE;
            TX_WAIT: begin
               tx_q <= TX_SHIFT;
               if (shift_mode) begin
                  tx_sr_q  <= {2'b11, 1'b1, tx_hold_q[7:1]}; // RULE24
                  tx_cnt_q <= spu_pkg::DATA_BITS - 4'h1;
               end else begin
                  tx_sr_q  <= {1'b1, nine ? ctrl_q[spu_pkg::CTL_TX_NINTH] : 1'b1,
                               tx_hold_q}; // RULE7 RULE23
                  tx_cnt_q <= nine ? spu_pkg::DATA_BITS + 4'h1 : spu_pkg::DATA_BITS; // RULE23
               end
            end
            TX_SHIFT: begin
               if (tx_cnt_q != 4'h0) begin
                  tx_sr_q  <= {1'b1, tx_sr_q[9:1]};
                  tx_cnt_q <= tx_cnt_q - 4'h1;
               end else begin
                  tx_q <= shift_mode ? TX_IDLE : TX_STOP; // RULE9
               end
            end
            TX_STOP: tx_q <= TX_IDLE;
         endcase
      end
   end

   // Transmit pin drivers; shift clock low in the first half of a cycle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         TXD      <= 1'b1;
         RXD_O    <= 1'b1;
         RXD_OE_N <= 1'b1;
      end else if (shift_mode) begin
         TXD      <= (sync_busy && tk.mphase < spu_pkg::SCLK_HIGH_PHASE) ? 1'b0 : 1'b1; // RULE24
         RXD_OE_N <= !(tx_q == TX_SHIFT);
         if (tx_q == TX_WAIT && tx_bound) RXD_O <= tx_hold_q[0];
         else if (tx_q == TX_SHIFT && tx_bound && tx_cnt_q != 4'h0) RXD_O <= tx_sr_q[0]; // RULE24
      end else begin
         RXD_OE_N <= 1'b1;
         RXD_O    <= 1'b1;
         if (tx_q == TX_WAIT && tx_bound) TXD <= 1'b0; // RULE23
         else if (tx_q == TX_SHIFT && tx_bound) TXD <= (tx_cnt_q != 4'h0) ? tx_sr_q[0] : 1'b1;
         else if (tx_q == TX_IDLE) TXD <= 1'b1;
      end
   end

   // Shift clock runs while either direction is active in shift mode
   assign sync_busy = (tx_q == TX_SHIFT) || (rx_q == RX_SYNC);

   // Look for start bits only when idle and enabled
   assign hunt = rx_q == RX_IDLE && !shift_mode && ctrl_q[spu_pkg::CTL_RX_EN]; // RULE6 RULE13

   // Address filter: ninth bit in 9-bit modes, stop bit in 8-bit mode
   assign mp_pass = !ctrl_q[spu_pkg::CTL_MP_EN] ||
                    (nine ? rx_ninth_q : bit_val); // RULE3 RULE4 RULE5

   // Completion: an unread byte blocks the new one, which is dropped
   always_comb begin
      ri_set        = 1'b0;
      rx_load_data  = rx_sr_q;
      rx_load_ninth = ctrl_q[spu_pkg::CTL_RX_NINTH];
      if (rx_q == RX_ASYNC && bit_stb &&
          rx_cnt_q == (nine ? spu_pkg::DATA_BITS + 4'h2 : spu_pkg::DATA_BITS + 4'h1)) begin
         ri_set        = !ctrl_q[spu_pkg::CTL_RX_FLAG] && mp_pass; // RULE10 RULE25
         rx_load_ninth = nine ? rx_ninth_q : bit_val; // RULE8
      end else if (rx_q == RX_SYNC && tk.mcycle && rx_cnt_q == spu_pkg::DATA_BITS) begin
         ri_set = 1'b1; // RULE10 RULE5
      end
   end

   // Receive engine
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_q       <= RX_IDLE;
         rx_sr_q    <= 8'hff;
         rx_ninth_q <= 1'b1;
         rx_cnt_q   <= 4'h0;
      end else begin
         unique case (rx_q)
            RX_IDLE: begin
               rx_cnt_q <= 4'h0;
               if (start_det) begin
                  rx_q <= RX_ASYNC; // RULE13
               end else if (shift_mode && tk.mcycle && tx_q == TX_IDLE &&
                            ctrl_q[spu_pkg::CTL_RX_EN] && !ctrl_q[spu_pkg::CTL_RX_FLAG]) begin
                  rx_q <= RX_SYNC; // RULE12
               end
            end
            RX_ASYNC: begin
               if (bit_stb) begin
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q == 4'h0 && bit_val) begin
                     rx_q <= RX_IDLE; // False start rejected
                  end else if (rx_cnt_q >= 4'h1 && rx_cnt_q <= spu_pkg::DATA_BITS) begin
                     rx_sr_q <= {bit_val, rx_sr_q[7:1]}; // RULE23
                  end else if (nine && rx_cnt_q == spu_pkg::DATA_BITS + 4'h1) begin
                     rx_ninth_q <= bit_val; // RULE8
                  end else if (rx_cnt_q > spu_pkg::DATA_BITS) begin
                     rx_q <= RX_IDLE;
                  end
               end
            end
            RX_SYNC: begin
               if (tk.mphase == spu_pkg::SYNC_SAMPLE_PH && rx_cnt_q < spu_pkg::DATA_BITS) begin
                  rx_sr_q  <= {RXD_I, rx_sr_q[7:1]}; // RULE24
                  rx_cnt_q <= rx_cnt_q + 4'h1;
               end
               if (tk.mcycle && rx_cnt_q == spu_pkg::DATA_BITS) rx_q <= RX_IDLE;
            end
            default: rx_q <= RX_IDLE;
         endcase
      end
   end

   // Receive buffer loads only when the flag is raised
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) rx_buf_q <= 8'h00;
      else if (ri_set) rx_buf_q <= rx_load_data; // RULE22 RULE25
   end

   // Single request from either flag
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) SERIAL_IRQ <= 1'b0;
      else SERIAL_IRQ <= ctrl_q[spu_pkg::CTL_TX_FLAG] | ctrl_q[spu_pkg::CTL_RX_FLAG]; // RULE26
   end
endmodule

// [dv/spu_top_properties.sv]
// Port-level assertions of the serial port block
module spu_top_properties (
   input wire logic        CLOCK,
   input wire logic        ARST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RXD_OE_N,
   input wire logic        TXD,
   input wire logic        SERIAL_IRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so clocking and reset are declared once
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   AST_READY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready missing after one wait state");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE))
      else $error("ready without an access phase");
   AST_ERR_READY: assert property (PSLVERR |-> PREADY)
      else $error("error response without ready");
   AST_ERR_DATA: assert property (PSLVERR |-> PRDATA == 32'h0)
      else $error("error response carries data");
   AST_UPPER_ZERO: assert property (PREADY && !PWRITE |-> PRDATA[31:17] == 15'h0)
      else $error("upper read data bits not zero");
   // Flags are sticky, so the request may only drop after a write
   AST_IRQ_CLEAR: assert property ($fell(SERIAL_IRQ) |->
      $past(PREADY && PWRITE, 1) || $past(PREADY && PWRITE, 2))
      else $error("interrupt request dropped without a write");
   AST_RESET_IDLE: assert property ($rose(ARST_N) |->
      TXD && RXD_OE_N && !SERIAL_IRQ)
      else $error("outputs not idle after reset");
   cover property (PSLVERR);
   cover property ($rose(SERIAL_IRQ));
   cover property ($fell(TXD));
endmodule

bind spu_top spu_top_properties spu_top_properties_inst (
   .CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_OE_N(RXD_OE_N),
   .TXD(TXD), .SERIAL_IRQ(SERIAL_IRQ)
);

// [dv/spu_station.sv]
// Remote serial station: frames onto the receive pin, decodes the transmit pin
module spu_station (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   int bit_clks = 32;
   // Line idles at the stop level between frames
   initial rxd = 1'b1;
   // Start 0, data LSB first, ninth bit marks address, stop 1
   task automatic send(input logic [8:0] d);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (bit_clks) @(posedge clk);
      end
   endtask
   // Samples mid-bit; q holds stop, ninth and data
   task automatic recv(output logic [9:0] q);
      @(negedge txd);
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
         if (i > 0)
            q[i-1] = txd;
         repeat (bit_clks) @(posedge clk);
      end
   endtask
endmodule

// [dv/test_spu_top.sv]
// Self-checking bench of the serial port block
module test_spu_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A_CTL = 12'h260;
   localparam logic [11:0] A_DAT = 12'h264;
   logic        CLOCK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
   logic        RXD_I, RXD_O, RXD_OE_N, TXD, SERIAL_IRQ;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   int          n_mismatch = 0;
   int          checked = 0;
   spu_top spu_top_inst (
      .CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .RXD_I(RXD_I), .RXD_O(RXD_O), .RXD_OE_N(RXD_OE_N),
      .TXD(TXD), .SERIAL_IRQ(SERIAL_IRQ));
   spu_station spu_station_inst (.clk(CLOCK), .txd(TXD), .rxd(RXD_I));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // APB cycle: request held until ready is sampled high, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK);
      while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic test_regs();
      apb(0, A_CTL, 0);
      chk(rd, 32'h0);
      apb(1, 12'ha70, 1);
      apb(0, A_CTL, 0);
      chk(rd, 32'h10);
      apb(0, 12'ha70, 0);
      chk(rd, 32'h1);
      apb(0, 12'h21c, 0);
      chk(rd, 32'h0);
      apb(1, 12'ha5c, 1);
      apb(0, 12'h21c, 0);
      chk(rd, 32'h80);
      apb(0, 12'h7fc, 0);
      chk(err, 1);
      repeat (120) @(posedge CLOCK);
      apb(0, A_CTL, 0);
      chk(rd, 32'h11);
      $display("test_regs done");
   endtask
   // Fixed 9-bit mode, doubled rate: 32 clocks per bit
   task automatic test_tx();
      logic [9:0] q;
      apb(1, A_CTL, 32'h88);
      fork
         spu_station_inst.recv(q);
         apb(1, A_DAT, 32'h5a);
      join
      chk(q, 10'h35a);
      apb(0, A_CTL, 0);
      chk(rd, 32'h8a);
      chk(SERIAL_IRQ, 1);
      apb(1, A_CTL, 32'h88);
      repeat (2) @(posedge CLOCK);
      chk(SERIAL_IRQ, 0);
      $display("test_tx done");
   endtask
   // Address filter, buffer overrun and receive enable
   task automatic test_rx();
      apb(1, A_CTL, 32'hb0);
      spu_station_inst.send(9'h0c3);
      apb(0, A_CTL, 0);
      chk(rd, 32'hb0);
      spu_station_inst.send(9'h1c3);
      apb(0, A_CTL, 0);
      chk(rd, 32'hb5);
      spu_station_inst.send(9'h13c);
      apb(0, A_DAT, 0);
      chk(rd, 32'hc3);
      apb(1, A_CTL, 32'ha0);
      spu_station_inst.send(9'h1a5);
      apb(0, A_CTL, 0);
      chk(rd & 32'h1, 32'h0);
      apb(1, 12'h234, 32'hff);
      apb(1, A_CTL, 32'h50);
      repeat (3100) @(posedge CLOCK);
      spu_station_inst.bit_clks = 192;
      spu_station_inst.send(9'h1e1);
      apb(0, A_CTL, 0);
      chk(rd, 32'h55);
      apb(0, A_DAT, 0);
      chk(rd, 32'he1);
      $display("test_rx done");
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   // Cuts a hang well past the expected run of under ten thousand cycles
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      ARST_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h0;
      PWDATA = 32'h0;
      repeat (3) @(posedge CLOCK);
      ARST_N <= 1'b1;
      @(posedge CLOCK);
      test_regs();
      test_tx();
      test_rx();
      end_sim();
   end
endmodule
